// ===== rtl/turnoff_seq.sv
// turn-off delay and output set-point slew sequencer
//
// How it works
// - six-bit turn-off delay, 1 ms per code, 0 to 63 ms
// - delay register bits 7:6 read zero; delay resets to zero
// - with slew control the delay ends when the output reaches zero
// - without slew control both switches turn off when the delay expires
// - set-point moves in 12.5 mV steps; hold time sets the rate
// - step hold time comes from dividing the power manager master clock
// - overcurrent during rising ramp trips the protection
// - tracking register resets to 0x08, slew control enabled
`timescale 1ns/1ps
`default_nettype none
`include "turnoff_regs.svh"
module turnoff_seq
  import turnoff_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `MS_CYCLES,
  parameter int unsigned MCLK_HZ   = `MCLK_HZ_DEFAULT
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic       reg_idx,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       turn_on_cmd,
  input  wire logic       turn_off_cmd,
  input  wire logic [8:0] target_code,
  input  wire logic       master_clk_pin,
  input  wire logic       oc_pin,
  output logic      [8:0] vout_code,
  output logic            switches_on,
  output logic            oc_trip
);
  localparam int unsigned CLK_PER_MTICK = `CLK_HZ / MCLK_HZ;

  // the delay counter is 22 bits wide, so 63 ms worth of cycles must fit in it
  if (MS_CYCLES < 1 || MS_CYCLES > 66576 ||
      MCLK_HZ < 100000 || MCLK_HZ > `CLK_HZ / 2) begin : g_bad_timing
    $error("turnoff_seq: unsupported timing parameters");
  end

  step_if trk ();

  logic [5:0]  off_delay_field;
  logic [6:0]  tracking_config;
  seq_state_e  state;
  logic [21:0] delay_left;
  logic        oc_meta;
  logic        oc_sync;
  logic        slew_ctrl_enable;
  logic [2:0]  rise_code;
  logic [2:0]  fall_code;
  logic [31:0] ramp_need;
  logic        going_up;

  step_timer u_step (
    .clk            (clk),
    .rst_b          (rst_b),
    .ce             (ce),
    .master_clk_pin (master_clk_pin),
    .trk            (trk)
  );

  assign slew_ctrl_enable = tracking_config[`SLEW_EN_BIT];
  assign rise_code        = tracking_config[`RISE_MSB:`RISE_LSB];
  assign fall_code        = tracking_config[`FALL_MSB:`FALL_LSB];

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      off_delay_field <= `OFF_DELAY_RESET;
      tracking_config <= `TRACKING_RESET;
    end else if (ce && reg_wr) begin
      if (reg_idx == `OFF_DELAY_IDX) begin
        off_delay_field <= reg_wdata[`OFF_DELAY_MSB:0];
      end else begin
        tracking_config <= reg_wdata[6:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (ce && reg_rd) begin
      if (reg_idx == `OFF_DELAY_IDX) begin
        reg_rdata <= {2'b00, off_delay_field};
      end else begin
        reg_rdata <= {1'b0, tracking_config};
      end
    end
  end

  // ----------------------------------------------------------------------
  // overcurrent pin synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      oc_meta <= 1'b0;
      oc_sync <= 1'b0;
    end else if (ce) begin
      oc_meta <= oc_pin;
      oc_sync <= oc_meta;
    end
  end

  // ----------------------------------------------------------------------
  // step timer control
  // ----------------------------------------------------------------------
  // rising rate for any upward move, falling rate otherwise
  assign going_up  = (state == ST_RAMP_UP) || (state == ST_ON && target_code > vout_code);
  assign trk.ticks = step_ticks_f(going_up ? rise_code : fall_code, MCLK_HZ);
  assign trk.run   = slew_ctrl_enable &&
                     (state == ST_RAMP_UP || state == ST_RAMP_DOWN ||
                      (state == ST_ON && target_code != vout_code));
  // clk cycles the controlled ramp-down needs from the present set-point
  assign ramp_need = 32'(vout_code) * 32'(trk.ticks) * CLK_PER_MTICK;

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state       <= ST_OFF;
      vout_code   <= 9'h000;
      switches_on <= 1'b0;
      oc_trip     <= 1'b0;
      delay_left  <= 22'h00_0000;
    end else if (ce) begin
      case (state)
        ST_OFF: begin
          if (turn_on_cmd) begin
            oc_trip     <= 1'b0;
            switches_on <= 1'b1;
            if (slew_ctrl_enable) begin
              vout_code <= 9'h000;
              state     <= ST_RAMP_UP;
            end else begin
              vout_code <= target_code;
              state     <= ST_ON;
            end
          end
        end
        ST_RAMP_UP: begin
          if (oc_sync) begin
            oc_trip     <= 1'b1;
            switches_on <= 1'b0;
            state       <= ST_OFF;
          end else if (turn_off_cmd) begin
            delay_left <= 22'(off_delay_field * MS_CYCLES);
            state      <= ST_OFF_WAIT;
          end else if (vout_code >= target_code) begin
            state <= ST_ON;
          end else if (trk.step) begin
            vout_code <= vout_code + 9'h001;
          end
        end
        ST_ON: begin
          if (turn_off_cmd) begin
            delay_left <= 22'(off_delay_field * MS_CYCLES);
            state      <= ST_OFF_WAIT;
          end else if (!slew_ctrl_enable) begin
            vout_code <= target_code;
          end else if (trk.step && target_code > vout_code) begin
            vout_code <= vout_code + 9'h001;
          end else if (trk.step && target_code < vout_code) begin
            vout_code <= vout_code - 9'h001;
          end
        end
        ST_OFF_WAIT: begin
          if (delay_left != 22'h00_0000) begin
            delay_left <= delay_left - 22'h00_0001;
          end
          // a too-short delay starts the ramp at once and overruns it
          if (slew_ctrl_enable && 32'(delay_left) <= ramp_need) begin
            state <= ST_RAMP_DOWN;
          end else if (!slew_ctrl_enable && delay_left == 22'h00_0000) begin
            switches_on <= 1'b0;
            state       <= ST_OFF;
          end
        end
        ST_RAMP_DOWN: begin
          if (vout_code == 9'h000) begin
            switches_on <= 1'b0;
            state       <= ST_OFF;
          end else if (trk.step) begin
            vout_code <= vout_code - 9'h001;
          end
        end
        default: state <= ST_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  AST_DELAY_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    ce && reg_wr && reg_idx == `OFF_DELAY_IDX |=> off_delay_field == $past(reg_wdata[5:0]))
    else $error("delay field not stored");

  AST_DELAY_READ_TOP: assert property (@(posedge clk) disable iff (!rst_b)
    ce && reg_rd && reg_idx == `OFF_DELAY_IDX |=> reg_rdata[7:6] == 2'b00 &&
    reg_rdata[5:0] == $past(off_delay_field))
    else $error("delay read wrong");

  AST_TRACK_RESET: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> tracking_config == 7'h08 && off_delay_field == 6'h00)
    else $error("tracking reset value wrong");

  AST_RAMP_END_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
    ce && state == ST_RAMP_DOWN && vout_code == 9'h000 |=> !switches_on && state == ST_OFF)
    else $error("ramp end did not turn off");

  AST_PLAIN_OFF: assert property (@(posedge clk) disable iff (!rst_b)
    ce && state == ST_OFF_WAIT && !slew_ctrl_enable && delay_left == 22'h00_0000
    |=> !switches_on && vout_code == $past(vout_code))
    else $error("plain turn-off wrong");

  AST_STEP_SIZE: assert property (@(posedge clk) disable iff (!rst_b)
    $past(slew_ctrl_enable) && $past(switches_on) && $past(state) != ST_OFF &&
    vout_code != $past(vout_code)
    |-> vout_code == $past(vout_code) + 9'h001 || vout_code == $past(vout_code) - 9'h001)
    else $error("set-point step not one code");

  AST_STEP_TIMED: assert property (@(posedge clk) disable iff (!rst_b)
    $past(slew_ctrl_enable) && $past(state) != ST_OFF && vout_code != $past(vout_code)
    |-> $past(trk.step))
    else $error("set-point moved without step");

  AST_OC_TRIP: assert property (@(posedge clk) disable iff (!rst_b)
    ce && state == ST_RAMP_UP && oc_sync |=> oc_trip && !switches_on && state == ST_OFF)
    else $error("overcurrent not tripped");

  AST_NO_SLEW_JUMP: assert property (@(posedge clk) disable iff (!rst_b)
    ce && state == ST_ON && !slew_ctrl_enable && !turn_off_cmd
    |=> vout_code == $past(target_code))
    else $error("set-point not applied at once");
endmodule : turnoff_seq
`default_nettype wire

// ===== rtl/turnoff_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef TURNOFF_REGS_SVH
`define TURNOFF_REGS_SVH
// ----------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------
`define OFF_DELAY_IDX        1'b0
`define TRACKING_IDX         1'b1
// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define OFF_DELAY_MSB        5
`define RISE_MSB             6
`define RISE_LSB             4
`define SLEW_EN_BIT          3
`define FALL_MSB             2
`define FALL_LSB             0
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define OFF_DELAY_RESET      6'h00
`define TRACKING_RESET       7'h08
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS        50
`define OFF_DELAY_UNIT_NS    1000000
`define MS_CYCLES            (`OFF_DELAY_UNIT_NS / `CLK_PERIOD_NS)
`define MCLK_HZ_DEFAULT      4000000
`define CLK_HZ               (1000000000 / `CLK_PERIOD_NS)
`endif

// ===== rtl/turnoff_pkg.sv
// types and helpers for the turn-off delay and slew ramp block
package turnoff_pkg;
  typedef enum logic [2:0] {
    ST_OFF,
    ST_RAMP_UP,
    ST_ON,
    ST_OFF_WAIT,
    ST_RAMP_DOWN
  } seq_state_e;

  // master clock ticks per 12.5 mV step for a rate code
  function automatic logic [15:0] step_ticks_f(input logic [2:0] code,
                                               input int unsigned mclk_hz);
    int unsigned rate_x10;
    int unsigned ticks;
    case (code)
      3'd0:    rate_x10 = 1;
      3'd1:    rate_x10 = 2;
      3'd2:    rate_x10 = 5;
      3'd3:    rate_x10 = 10;
      3'd4:    rate_x10 = 20;
      3'd5:    rate_x10 = 50;
      default: rate_x10 = 83;
    endcase
    ticks = ((mclk_hz / 1000) * 125) / (rate_x10 * 1000);
    if (ticks == 0) begin
      ticks = 1;
    end
    return ticks[15:0];
  endfunction : step_ticks_f
endpackage : turnoff_pkg

// ===== rtl/step_if.sv
// link between sequencer and step timer
`timescale 1ns/1ps
`default_nettype none
interface step_if;
  logic [15:0] ticks;
  logic        run;
  logic        step;
  modport seq   (output ticks, output run, input step);
  modport timer (input ticks, input run, output step);
endinterface : step_if
`default_nettype wire

// ===== rtl/step_timer.sv
// divides the power manager master clock into step pulses
`timescale 1ns/1ps
`default_nettype none
module step_timer (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic master_clk_pin,
  step_if.timer     trk
);
  logic        mclk_meta;
  logic        mclk_sync;
  logic        mclk_last;
  logic [15:0] tick_cnt;

  // ----------------------------------------------------------------------
  // synchroniser and edge detect
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mclk_meta <= 1'b0;
      mclk_sync <= 1'b0;
      mclk_last <= 1'b0;
    end else if (ce) begin
      mclk_meta <= master_clk_pin;
      mclk_sync <= mclk_meta;
      mclk_last <= mclk_sync;
    end
  end

  // ----------------------------------------------------------------------
  // divider: restarts from zero whenever no ramp runs, so step phase follows this block's ramp start
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tick_cnt <= 16'h0000;
      trk.step <= 1'b0;
    end else if (ce) begin
      trk.step <= 1'b0;
      if (!trk.run) begin
        tick_cnt <= 16'h0000;
      end else if (mclk_sync && !mclk_last) begin
        if (tick_cnt + 16'h0001 >= trk.ticks) begin
          tick_cnt <= 16'h0000;
          trk.step <= 1'b1;
        end else begin
          tick_cnt <= tick_cnt + 16'h0001;
        end
      end
    end
  end
endmodule : step_timer
`default_nettype wire

// ===== tb/power_manager_model.sv
// master clock source standing in for the power manager
`timescale 1ns/1ps
`default_nettype none
module power_manager_model #(
  parameter int HALF_NS = 125
) (
  output logic master_clk
);
  // runs free at a fixed 7 ns offset from clk, so its edges always land at the same points in a cycle
  initial begin
    master_clk = 1'b0;
    #7;
    forever #(HALF_NS) master_clk = ~master_clk;
  end
endmodule : power_manager_model
`default_nettype wire

// ===== tb/tb_turnoff_seq.sv
// self-checking bench for the turn-off delay and slew sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_turnoff_seq;
  import turnoff_pkg::*;
  // short millisecond keeps the delay runs brief
  localparam int MS = 100;
  // master clock ticks per step for rate codes 0..7 at 4 MHz; 5 clk cycles per tick
  localparam int TK [8] = '{500, 250, 100, 50, 25, 10, 6, 6};
  logic       clk;
  logic       rst_b;
  logic       ce;
  logic       reg_wr;
  logic       reg_rd;
  logic       reg_idx;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       turn_on_cmd;
  logic       turn_off_cmd;
  logic [8:0] target_code;
  logic       master_clk_pin;
  logic       oc_pin;
  logic [8:0] vout_code;
  logic       switches_on;
  logic       oc_trip;
  int         fails;
  int         tests_run;
  int         n;

  power_manager_model i_power_manager_model (.master_clk(master_clk_pin));

  turnoff_seq #(.MS_CYCLES(MS)) i_turnoff_seq (
    .clk(clk), .rst_b(rst_b), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .turn_on_cmd(turn_on_cmd), .turn_off_cmd(turn_off_cmd), .target_code(target_code),
    .master_clk_pin(master_clk_pin), .oc_pin(oc_pin), .vout_code(vout_code),
    .switches_on(switches_on), .oc_trip(oc_trip)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic i, input logic [7:0] d);
    @(negedge clk);
    reg_idx = i;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic i, input logic [7:0] e);
    @(negedge clk);
    reg_idx = i;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    chk(16'(reg_rdata), 16'(e));
  endtask : rd

  task automatic pulse(input logic on);
    @(negedge clk);
    turn_on_cmd = on;
    turn_off_cmd = !on;
    @(negedge clk);
    turn_on_cmd = 1'b0;
    turn_off_cmd = 1'b0;
  endtask : pulse

  // waits for a set-point; any move bigger than one code is a fault
  task automatic wait_v(input logic [8:0] v, input int lim, output int k);
    logic [8:0] p;
    p = vout_code;
    k = 0;
    while (vout_code !== v && k < lim) begin
      @(negedge clk);
      k++;
      if (vout_code !== p && vout_code !== p + 9'h001 && vout_code !== p - 9'h001)
        chk(16'(vout_code), 16'(p));
      p = vout_code;
    end
  endtask : wait_v

  task automatic results;
    if (fails == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    results();
  end

  // ----------------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------------
  initial begin
    fails = 0;
    tests_run = 0;
    rst_b = 1'b0;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_idx = 1'b0;
    reg_wdata = 8'h00;
    turn_on_cmd = 1'b0;
    turn_off_cmd = 1'b0;
    target_code = 9'h000;
    oc_pin = 1'b0;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    rd(1'b0, 8'h00);
    rd(1'b1, 8'h08);
    wr(1'b0, 8'hff);
    rd(1'b0, 8'h3f);
    // clock enable low: the write strobe must be ignored
    ce = 1'b0;
    wr(1'b0, 8'h15);
    ce = 1'b1;
    rd(1'b0, 8'h3f);
    wr(1'b1, 8'hff);
    rd(1'b1, 8'h7f);
    // slew off: set-point jumps, switches drop when the delay runs out
    wr(1'b1, 8'h00);
    wr(1'b0, 8'h02);
    target_code = 9'h005;
    pulse(1'b1);
    @(negedge clk);
    chk(16'(vout_code), 16'h0005);
    pulse(1'b0);
    n = 0;
    while (switches_on !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n >= 2 * MS - 1 && n <= 2 * MS + 3), 16'h0001);
    chk(16'(vout_code), 16'h0005);
    // every rate code, up and down, one step each
    wr(1'b0, 8'h00);
    target_code = 9'h001;
    for (int c = 0; c < 8; c++) begin
      wr(1'b1, 8'((c << 4) | 8 | c));
      pulse(1'b1);
      wait_v(9'h001, 5 * TK[c] + 20, n);
      chk(16'(n >= 5 * TK[c] - 6 && n <= 5 * TK[c] + 10), 16'h0001);
      pulse(1'b0);
      wait_v(9'h000, 5 * TK[c] + 20, n);
      chk(16'(n >= 5 * TK[c] - 6 && n <= 5 * TK[c] + 10), 16'h0001);
      repeat (3) @(negedge clk);
    end
    // ramp-down fits inside a 3 ms delay: 2 steps of 50 cycles
    wr(1'b1, 8'h5d);
    wr(1'b0, 8'h03);
    target_code = 9'h004;
    pulse(1'b1);
    wait_v(9'h004, 300, n);
    chk(16'(vout_code), 16'h0004);
    // set-point lowered while on: two falling steps of 50 cycles
    target_code = 9'h002;
    wait_v(9'h002, 300, n);
    chk(16'(n >= 85 && n <= 110), 16'h0001);
    chk(16'(vout_code), 16'h0002);
    pulse(1'b0);
    wait_v(9'h000, 500, n);
    chk(16'(n >= 3 * MS - 12 && n <= 3 * MS + 12), 16'h0001);
    @(negedge clk);
    chk(16'(switches_on), 16'h0000);
    // overcurrent while ramping up
    wr(1'b1, 8'h08);
    pulse(1'b1);
    repeat (20) @(negedge clk);
    oc_pin = 1'b1;
    repeat (5) @(negedge clk);
    chk(16'(oc_trip), 16'h0001);
    chk(16'(switches_on), 16'h0000);
    oc_pin = 1'b0;
    pulse(1'b1);
    chk(16'(oc_trip), 16'h0000);
    results();
  end
endmodule : tb_turnoff_seq
`default_nettype wire
